// [include/tiop_pkg.sv]
// Shared constants and types for the timed I/O port block
package tiop_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DW  = 32;  // Transfer register and pin count
  localparam int CW  = 16;  // Port counter width
  localparam int NCB = 6;   // Clock blocks per tile
  localparam int DVW = 8;   // Clock block divider width

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_DATA  = 8'h04;
  localparam logic [7:0] A_COND  = 8'h08;
  localparam logic [7:0] A_TIME  = 8'h0C;
  localparam logic [7:0] A_COUNT = 8'h10;
  localparam logic [7:0] A_TSTMP = 8'h14;
  localparam logic [7:0] A_STAT  = 8'h18;
  localparam logic [7:0] A_SHARE = 8'h1C;
  localparam logic [7:0] A_CB1   = 8'h24;  // Blocks 1..5, one word each
  localparam logic [7:0] A_CBEND = 8'h38;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int C_EN  = 0;   // Port enable
  localparam int C_OUT = 1;   // Direction, 1 = output
  localparam int C_OC  = 2;   // Open-collector drive
  localparam int C_WL  = 3;   // Width code, 3 bits
  localparam int C_CBL = 6;   // Clock block select, 3 bits
  localparam int C_CML = 9;   // Condition mode, 2 bits
  localparam int C_TMD = 11;  // Timed transfer
  localparam int C_STB = 12;  // Use input ready strobe
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Clock block config fields
  localparam int B_SRC = 0;   // 1 = external 1-bit clock pin
  localparam int B_DVL = 8;   // Divider, 0 = undivided

  // Status fields
  localparam int S_INV = 0;
  localparam int S_OFL = 1;
  localparam int S_BSY = 2;

  // Pins reclaimed by the serial link
  localparam logic [DW-1:0] LINK_MASK = 32'h0000_03FF;
  // Reference clock: block 0 ticks on every pclk cycle when this is 1, and never otherwise
  localparam int REF_DIV = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CM_NONE, CM_EQ, CM_NE} tiop_cond_e;
  typedef enum logic {ST_IDLE, ST_SHIFT} tiop_state_e;

  // Width code to bit count: 1, 4, 8, 16, 32
  function automatic logic [5:0] tiop_width(input logic [2:0] code);
    unique case (code)
      3'h0:    tiop_width = 6'h01;
      3'h1:    tiop_width = 6'h04;
      3'h2:    tiop_width = 6'h08;
      3'h3:    tiop_width = 6'h10;
      default: tiop_width = 6'h20;
    endcase
  endfunction : tiop_width

  // Mask of pins a port of this width covers
  function automatic logic [DW-1:0] tiop_mask(input logic [2:0] code);
    logic [DW:0] m;  // One bit wider so a 32-bit port does not overflow
    m = (33'h1_0000_0000 >> (6'h20 - tiop_width(code))) - 33'h1;
    tiop_mask = m[DW-1:0];
  endfunction : tiop_mask

endpackage : tiop_pkg

// [rtl/tiop_clkblk.sv]
// Programmable clock block: tick enable from reference or pin clock
`timescale 1ns/100ps
module tiop_clkblk (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ref_tick,
  input  wire logic                pin_clk,
  input  wire logic                use_pin,
  input  wire logic [tiop_pkg::DVW-1:0] div,
  output logic                     tick
);
  import tiop_pkg::*;

  logic           pin_q;
  logic [DVW-1:0] cnt;
  logic           src;

  // Rising edge of the synchronised pin, or the reference tick
  assign src = use_pin ? (pin_clk & ~pin_q) : ref_tick;

  // --------------------------------------------------------------
  // Divider
  // --------------------------------------------------------------
  // Pin history for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_q <= 1'b0;
    else          pin_q <= pin_clk;
  end

  // One tick per div+1 source edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (src) begin
        if (cnt >= div) begin
          cnt  <= '0;
          tick <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule : tiop_clkblk

// [rtl/tiop_sync.sv]
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module tiop_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // --------------------------------------------------------------
  // Synchroniser chain
  // --------------------------------------------------------------
  // First stage is read by the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : tiop_sync

// [rtl/tiop_top.sv]
// Timed I/O port with clock blocks, APB register access
`timescale 1ns/100ps
module tiop_top (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [tiop_pkg::DW-1:0] pin_in,
  output logic      [tiop_pkg::DW-1:0] pin_out,
  output logic      [tiop_pkg::DW-1:0] pin_oe,
  input  wire logic                   ext_clk_pin,
  input  wire logic                   input_ready_strobe,
  output logic                        output_ready_strobe,
  input  wire logic                   link_enable,
  output logic                        port_event
);
  import tiop_pkg::*;

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  logic [31:0]      ctrl;
  logic [DW-1:0]    cond_val;
  logic [CW-1:0]    time_val;
  logic [DW-1:0]    share;
  logic [15:0]      cb_cfg [1:NCB-1];
  logic [CW-1:0]    count;
  logic [CW-1:0]    tstamp;
  logic [DW-1:0]    xfer_in;
  logic [DW-1:0]    xfer_out;
  logic             in_valid;
  logic             out_full;
  logic [DW-1:0]    shreg;
  logic [DW-1:0]    pin_val;
  logic [5:0]       steps;
  tiop_state_e      state;
  logic [DW-1:0]    pin_s;
  logic             strobe_s;
  logic             clk_pin_s;
  logic [NCB-1:0]   cb_tick;
  logic             tick;
  logic             wr;
  logic             rd_setup;
  logic             rd_acc;
  logic             mapped;
  logic [5:0]       wbits;
  logic [DW-1:0]    wmsk;
  logic [DW-1:0]    own;
  logic [DW-1:0]    samp;
  logic             cond_ok;
  logic             time_ok;
  logic             start;
  logic             done;
  logic             strobe_ok;
  logic [31:0]      next_rdata;
  logic [DW-1:0]    next_shreg;

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  // Pins, strobe and clock pin come from outside the pclk domain
  tiop_sync #(.W(DW)) u_sync_pin (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pin_in),
    .q       (pin_s)
  );

  tiop_sync #(.W(2)) u_sync_ctl (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({input_ready_strobe, ext_clk_pin}),
    .q       ({strobe_s, clk_pin_s})
  );

  // --------------------------------------------------------------
  // Clock blocks
  // --------------------------------------------------------------
  // Block 0 is the reference tick; pclk is the fastest rate we have
  assign cb_tick[0] = (REF_DIV == 1);

  genvar gi;
  generate
    for (gi = 1; gi < NCB; gi++) begin : g_cb
      tiop_clkblk u_cb (
        .pclk     (pclk),
        .presetn  (presetn),
        .ref_tick (cb_tick[0]),
        .pin_clk  (clk_pin_s),
        .use_pin  (cb_cfg[gi][B_SRC]),
        .div      (cb_cfg[gi][B_DVL +: DVW]),
        .tick     (cb_tick[gi])
      );
    end
  endgenerate

  // Selected block; out-of-range selects give no tick
  assign tick = (ctrl[C_CBL +: 3] < 3'(NCB)) ? cb_tick[ctrl[C_CBL +: 3]] : 1'b0;

  // --------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------
  // Zero-wait slave: every access ends in its first access cycle
  assign pready   = 1'b1;
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign rd_acc   = psel & penable & ~pwrite;
  assign mapped   = (paddr[1:0] == 2'b00) &&
                    (paddr <= A_SHARE ||
                     (paddr >= A_CB1 && paddr < A_CBEND));
  assign pslverr  = psel & penable & ~mapped;

  // Read mux, latched in the setup cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      A_CTRL:  next_rdata = ctrl;
      A_DATA:  next_rdata = xfer_in;
      A_COND:  next_rdata = cond_val;
      A_TIME:  next_rdata = {16'h0000, time_val};
      A_COUNT: next_rdata = {16'h0000, count};
      A_TSTMP: next_rdata = {16'h0000, tstamp};
      A_STAT:  next_rdata = {29'h0, state == ST_SHIFT, out_full, in_valid};
      A_SHARE: next_rdata = share;
      default: begin
        if (paddr >= A_CB1 && paddr < A_CBEND)
          next_rdata = {16'h0000, cb_cfg[3'((paddr - A_CB1) >> 2) + 3'h1]};
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)      prdata <= 32'h0000_0000;
    else if (rd_setup) prdata <= next_rdata;
  end

  // --------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------
  // Reset attaches the port to block 0 and disables it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= CTRL_RST;
      cond_val <= '0;
      time_val <= '0;
      share    <= '0;
    end else if (wr) begin
      unique case (paddr)
        A_CTRL:  ctrl     <= pwdata;
        A_COND:  cond_val <= pwdata;
        A_TIME:  time_val <= pwdata[CW-1:0];
        A_SHARE: share    <= pwdata;
        default: ;
      endcase
    end
  end

  // Clock block settings, one word per programmable block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 1; i < NCB; i++) cb_cfg[i] <= 16'h0000;
    end else if (wr && paddr >= A_CB1 && paddr < A_CBEND) begin
      cb_cfg[3'((paddr - A_CB1) >> 2) + 3'h1] <= pwdata[15:0];
    end
  end

  // --------------------------------------------------------------
  // Port counter
  // --------------------------------------------------------------
  // Free-running on the selected block; wraps naturally at 16 bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)  count <= '0;
    else if (tick) count <= count + 1'b1;
  end

  // --------------------------------------------------------------
  // Transfer control
  // --------------------------------------------------------------
  assign wbits = tiop_width(ctrl[C_WL +: 3]);
  assign wmsk  = tiop_mask(ctrl[C_WL +: 3]);
  // Link first, then narrower ports, take pins from this port
  assign own   = ~share & ~(link_enable ? LINK_MASK : '0);
  // Lost pins read as zero but the word keeps its width
  assign samp  = pin_s & own & wmsk;

  // Condition on the pin value gates the start of a sample
  always_comb begin
    unique case (tiop_cond_e'(ctrl[C_CML +: 2]))
      CM_EQ:   cond_ok = (samp == (cond_val & wmsk));
      CM_NE:   cond_ok = (samp != (cond_val & wmsk));
      default: cond_ok = 1'b1;
    endcase
  end

  // Deferred I/O waits for the counter to reach the set time
  assign time_ok   = ~ctrl[C_TMD] | (count == time_val);
  assign strobe_ok = ~ctrl[C_STB] | strobe_s;
  assign start = ctrl[C_EN] & tick & (state == ST_IDLE) & time_ok &
                 (ctrl[C_OUT] ? out_full : (~in_valid & cond_ok & strobe_ok));
  assign done  = (state == ST_SHIFT) & tick & (steps == 6'h01) &
                 (ctrl[C_OUT] | strobe_ok);

  // Shift register: out moves low bits first, in fills from the top
  always_comb begin
    next_shreg = shreg >> wbits;
    if (!ctrl[C_OUT]) next_shreg = next_shreg | (samp << (6'h20 - wbits));
  end

  // State and step count; a word takes 32/width ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      steps <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_SHIFT;
            steps <= 6'(DW / wbits);
          end
        end
        ST_SHIFT: begin
          if (!ctrl[C_EN]) state <= ST_IDLE;
          else if (done) state <= ST_IDLE;
          else if (tick && (ctrl[C_OUT] || strobe_ok)) steps <= steps - 6'h01;
        end
      endcase
    end
  end

  // SERDES data path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg   <= '0;
      pin_val <= '0;
    end else if (start && ctrl[C_OUT]) begin
      shreg <= xfer_out;
    end else if (state == ST_SHIFT && tick && (ctrl[C_OUT] || strobe_ok)) begin
      shreg <= next_shreg;
      if (ctrl[C_OUT]) pin_val <= shreg & wmsk;
    end
  end

  // Output ready strobe accompanies each output slice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) output_ready_strobe <= 1'b0;
    else output_ready_strobe <= (state == ST_SHIFT) & tick & ctrl[C_OUT];
  end

  // --------------------------------------------------------------
  // Transfer registers and timestamp
  // --------------------------------------------------------------
  // Write loads the output word; a write racing the load wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_out <= '0;
      out_full <= 1'b0;
    end else if (wr && paddr == A_DATA) begin
      xfer_out <= pwdata;
      out_full <= 1'b1;
    end else if (start && ctrl[C_OUT]) begin
      out_full <= 1'b0;
    end
  end

  // Completed input word; arrival beats a clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_in  <= '0;
      in_valid <= 1'b0;
    end else if (done && !ctrl[C_OUT]) begin
      xfer_in  <= next_shreg;
      in_valid <= 1'b1;
    end else if (rd_acc && paddr == A_DATA) begin
      in_valid <= 1'b0;
    end
  end

  // Counter captured when a word moves to or from the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)  tstamp <= '0;
    else if (start) tstamp <= count;
  end

  // Event straight to the scheduler, no interrupt logic between
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) port_event <= 1'b0;
    else          port_event <= done;
  end

  // --------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------
  // Open collector only ever drives zero, one floats
  assign pin_out = ctrl[C_OC] ? '0 : pin_val;
  assign pin_oe  = (ctrl[C_EN] & ctrl[C_OUT]) ?
                   (own & wmsk & (ctrl[C_OC] ? ~pin_val : '1)) : '0;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  property p_zero_wait;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> (penable |-> pready);
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access stalled");

  property p_reset_cb0;
    @(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> (ctrl[C_CBL +: 3] == 3'h0 && !ctrl[C_EN]);
  endproperty
  a_reset_cb0: assert property (p_reset_cb0) else $error("not on block 0");

  property p_cnt_step;
    @(posedge pclk) disable iff (!presetn)
      tick |=> count == $past(count) + 16'h0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter missed tick");

  property p_cnt_hold;
    @(posedge pclk) disable iff (!presetn)
      !tick |=> $stable(count);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved");

  property p_oc_low;
    @(posedge pclk) disable iff (!presetn)
      ctrl[C_OC] |-> (pin_out == '0 && (pin_oe & pin_val) == '0);
  endproperty
  a_oc_low: assert property (p_oc_low) else $error("open collector drove high");

  property p_link_pins;
    @(posedge pclk) disable iff (!presetn)
      link_enable |-> (pin_oe & LINK_MASK) == '0;
  endproperty
  a_link_pins: assert property (p_link_pins) else $error("link pins driven");

  property p_share_pins;
    @(posedge pclk) disable iff (!presetn)
      (pin_oe & share) == '0;
  endproperty
  a_share_pins: assert property (p_share_pins) else $error("shared pin driven");

  property p_tstamp;
    @(posedge pclk) disable iff (!presetn)
      start |=> tstamp == $past(count);
  endproperty
  a_tstamp: assert property (p_tstamp) else $error("timestamp wrong");

  property p_steps;
    @(posedge pclk) disable iff (!presetn)
      start |=> (steps == 6'(DW / $past(wbits)));
  endproperty
  a_steps: assert property (p_steps) else $error("word not full width");

  property p_event;
    @(posedge pclk) disable iff (!presetn)
      (done && !ctrl[C_OUT]) |=> (port_event && in_valid);
  endproperty
  a_event: assert property (p_event) else $error("event lost");

  property p_strobe;
    @(posedge pclk) disable iff (!presetn)
      output_ready_strobe |-> ($past(state) == ST_SHIFT && $past(ctrl[C_OUT]));
  endproperty
  a_strobe: assert property (p_strobe) else $error("stray ready strobe");

  c_out_word: cover property (@(posedge pclk) start && ctrl[C_OUT]);
  c_in_word:  cover property (@(posedge pclk) done && !ctrl[C_OUT]);
  c_timed:    cover property (@(posedge pclk) start && ctrl[C_TMD]);
  c_pin_clk:  cover property (@(posedge pclk) cb_tick[1] && cb_cfg[1][B_SRC]);

endmodule : tiop_top

// [verif/tiop_pins_model.sv]
// Model of the hardware wired to the port pins
`timescale 1ns/100ps
module tiop_pins_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] ext_val,
  input  wire logic        clk_run,
  input  wire logic        strobe_on,
  output logic      [31:0] pin_in,
  output logic             ext_clk_pin,
  output logic             input_ready_strobe
);
  logic [1:0] phase;

  // Wire level: a driven pin wins, else the far device drives it
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_val[i];
    end
  end

  // Input qualifier from the far logic
  assign input_ready_strobe = strobe_on;

  // Application clock; stops low so no stray edge reaches a block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase       <= 2'h0;
      ext_clk_pin <= 1'b0;
    end else if (clk_run || ext_clk_pin) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        ext_clk_pin <= ~ext_clk_pin;
      end
    end
  end
endmodule : tiop_pins_model

// [verif/tiop_tb_top.sv]
// Self-checking bench for the timed I/O port
`timescale 1ns/100ps
module tiop_tb_top;
  import tiop_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, link_enable = 1'b0, clk_run = 1'b0, strobe_on = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, ext_val = 32'h0;
  logic [31:0] prdata, pin_in, pin_out, pin_oe, rd, d, c0;
  logic        pready, pslverr, ext_clk_pin, irs, ors, port_event, err, seen;
  int          failures = 0, n_compared = 0, k;
  logic [31:0] rs = 32'h0000_1376;

  always #10 pclk = ~pclk;

  tiop_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .ext_clk_pin(ext_clk_pin), .input_ready_strobe(irs), .output_ready_strobe(ors),
    .link_enable(link_enable), .port_event(port_event));
  tiop_pins_model far (.pclk(pclk), .presetn(presetn), .pin_out(pin_out), .pin_oe(pin_oe),
    .ext_val(ext_val), .clk_run(clk_run), .strobe_on(strobe_on), .pin_in(pin_in),
    .ext_clk_pin(ext_clk_pin), .input_ready_strobe(irs));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  // Pins the port should drive for a full-width output word
  function automatic logic [31:0] drive_mask(logic oc, logic [31:0] v, logic [31:0] taken);
    return (oc ? ~v : 32'hFFFF_FFFF) & ~taken;
  endfunction : drive_mask

  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; answer taken at the edge where pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk("wait", 32'h1, 32'(k));
    if (k >= 20) final_report();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bounded wait for the word event or the output strobe
  task automatic wait_hi(input bit ev);
    for (k = 0; k < 200; k++) begin
      @(negedge pclk);
      if ((ev ? port_event : ors) === 1'b1) return;
    end
    chk("timeout", 32'h0, 32'h1);
    final_report();
  endtask : wait_hi

  // No word may complete for a while
  task automatic quiet();
    seen = 1'b0;
    repeat (40) begin
      @(negedge pclk);
      if (port_event === 1'b1) seen = 1'b1;
    end
    @(posedge pclk);
  endtask : quiet

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, A_CTRL, 32'h0);
    chk("ctrl", CTRL_RST, rd);
    for (int i = 0; i < 2; i++) begin
      apb(i[0], i[0] ? A_CBEND : 8'h20, rnd());
      chk("slverr", 32'h1, 32'(err));
    end
    // Full-width output, push-pull then open collector
    for (int oc = 0; oc < 2; oc++) begin
      apb(1, A_CTRL, 32'h0000_0023 | (32'(oc) << C_OC));
      apb(0, A_COUNT, 32'h0);
      c0 = rd;
      d = rnd();
      apb(1, A_DATA, d);
      wait_hi(1);
      chk("pins", oc ? 32'h0 : d, pin_out);
      chk("oe", drive_mask(oc[0], d, 32'h0), pin_oe);
      apb(0, A_TSTMP, 32'h0);
      chk("tstamp", 32'h1, 32'(16'(rd - c0) inside {[3:6]}));
    end
    // Counter steps once per reference tick
    apb(0, A_COUNT, 32'h0);
    c0 = rd;
    apb(0, A_COUNT, 32'h0);
    chk("count", 32'(16'(c0 + 32'h3)), rd);
    // Deferred output waits for the counter to meet the set time
    apb(1, A_CTRL, 32'h0000_0823);
    apb(0, A_COUNT, 32'h0);
    c0 = 32'(16'(rd + 32'h28));
    apb(1, A_TIME, c0);
    apb(1, A_DATA, rnd());
    wait_hi(1);
    apb(0, A_TSTMP, 32'h0);
    chk("timed", c0, rd);
    // Link and narrower ports take pins away
    apb(1, A_CTRL, 32'h0000_0023);
    link_enable <= 1'b1;
    apb(1, A_SHARE, 32'h00F0_0000);
    @(negedge pclk);
    chk("oe", drive_mask(1'b0, d, LINK_MASK | 32'h00F0_0000), pin_oe);
    apb(1, A_SHARE, 32'h0);
    link_enable <= 1'b0;
    // Byte port: four slices, lowest first, each with a strobe
    apb(1, A_CTRL, 32'h0000_0013);
    d = rnd();
    apb(1, A_DATA, d);
    for (int i = 0; i < 4; i++) begin
      wait_hi(0);
      chk("slice", 32'(d[8*i +: 8]), pin_out & 32'hFF);
    end
    chk("oe8", 32'hFF, pin_oe);
    // Conditional, strobed input
    @(posedge pclk);
    d = rnd();
    ext_val   <= ~d;
    strobe_on <= 1'b1;
    apb(1, A_COND, d);
    apb(1, A_CTRL, 32'h0000_1221);
    quiet();
    chk("held", 32'h0, 32'(seen));
    chk("oe_in", 32'h0, pin_oe);
    strobe_on <= 1'b0;
    repeat (5) @(posedge pclk);
    ext_val <= d;
    quiet();
    chk("held", 32'h0, 32'(seen));
    strobe_on <= 1'b1;
    wait_hi(1);
    apb(0, A_STAT, 32'h0);
    chk("valid", 32'h1, rd & 32'h1);
    apb(0, A_DATA, 32'h0);
    chk("din", d, rd);
    // Block 1 from the pin clock, halved then undivided
    apb(1, A_CTRL, 32'h0000_0040);
    for (int j = 0; j < 2; j++) begin
      apb(1, A_CB1, j ? 32'h0000_0001 : 32'h0000_0101);
      apb(0, A_COUNT, 32'h0);
      c0 = rd;
      clk_run <= 1'b1;
      repeat (64) @(posedge pclk);
      clk_run <= 1'b0;
      repeat (20) @(posedge pclk);
      apb(0, A_COUNT, 32'h0);
      chk("cbcount", 32'(16'(c0 + (j ? 32'h8 : 32'h4))), rd);
    end
    final_report();
  end
endmodule : tiop_tb_top
